// ---- core/gfs_pkg.sv ----
// Shared constants and types for the gas fault supervisor
package gfs_pkg;
  // Timing base: 40 MHz clock
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SEC_NS          = 1_000_000_000;
  localparam int TICK_CYCLES     = SEC_NS / CLK_PERIOD_NS;
  // Operator and supervision times in seconds, span due time in days
  localparam int PROMPT_S        = 2;
  localparam int ENTRY_HOLD_S    = 3;
  localparam int SAVE_HOLD_S     = 3;
  localparam int VIEW_HOLD_S     = 1;
  localparam int IDLE_TIMEOUT_S  = 15;
  localparam int NAME_REPEATS    = 4;
  localparam int FAULT_MSG_S     = 60;
  localparam int SEC_PER_DAY     = 86400;
  localparam int SPAN_DUE_DAYS   = 180;
  // Measurement limits (%LEL, degC, mA, 10 mV, ohm)
  localparam int FULL_SCALE      = 100;
  localparam int SERIAL_CAP      = 110;
  localparam int ZERO_DRIFT_MIN  = -10;
  localparam int TEMP_MIN        = -40;
  localparam int TEMP_MAX        = 75;
  localparam int BRIDGE_MA_NOM   = 200;
  localparam int BRIDGE_MA_TOL   = 50;
  localparam int BRIDGE_CV_MAX   = 350;
  localparam int BRIDGE_CV_MIN   = 180;
  localparam int LOOP_OHM_MAX    = 1000;
  localparam int SUPPLY_CV_MIN   = 1150;
  localparam int SUPPLY_CV_MAX   = 2800;
  localparam int LIFE_MAX        = 100;
  localparam int LIFE_REPLACE    = 25;
  // Status word bit positions
  localparam int B_GLOBAL = 0;
  localparam int B_SPAN   = 1;
  localparam int B_TEMP   = 2;
  localparam int B_LOOP   = 3;
  localparam int B_VIN    = 4;
  localparam int B_MEM    = 5;
  localparam int B_PROC   = 6;
  localparam int B_CLEAR  = 7;
  localparam int B_STAB   = 8;
  localparam int B_RANGE  = 9;
  localparam int B_CELL   = 10;
  localparam int B_ZERO   = 11;
  localparam int B_INCAL  = 14;
  // Register offsets and reset values
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_LIFE   = 8'h08;
  localparam logic [7:0] A_DAYS   = 8'h0C;
  localparam logic [7:0] A_CONC   = 8'h10;
  localparam logic [7:0] A_LOOP   = 8'h14;
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_ENERG = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [6:0] LIFE_RST = 7'h64;
  // Measurement inputs
  typedef struct packed {
    logic signed [15:0] gas;
    logic signed [15:0] temp;
    logic [15:0]        bridge_ma;
    logic [15:0]        bridge_cv;
    logic [15:0]        loop_ohm;
    logic [15:0]        supply_cv;
  } gfs_meas_t;
  // Calibration and firmware events
  typedef struct packed {
    logic       zero_active;
    logic       span_active;
    logic       zero_ok;
    logic       span_ok;
    logic       span_range_fail;
    logic       span_stab_fail;
    logic       proc_err;
    logic       mem_err;
    logic [6:0] life;
  } gfs_cal_t;
  // Loop output level
  typedef enum logic [1:0] {
    LOOP_MEAS = 2'h0, LOOP_0MA = 2'h1, LOOP_2MA = 2'h2, LOOP_22MA = 2'h3
  } gfs_loop_t;
  // Operator menu states
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01, ST_VIEW = 5'h02, ST_ITEM = 5'h04,
    ST_SET_LATCH = 5'h08, ST_SET_ENERG = 5'h10
  } gfs_state_t;
endpackage

// ---- core/gfs_supervisor.sv ----
// Fault supervision, fault relay, loop level and operator menu
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module gfs_supervisor import gfs_pkg::*; #(
  parameter int TICK       = TICK_CYCLES,
  parameter int DAY_SECS   = SEC_PER_DAY
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire gfs_meas_t   meas_i,
  input  wire gfs_cal_t    cal_i,
  input  wire logic        magnet_switch_up_i,
  input  wire logic        magnet_switch_down_i,
  input  wire logic        fault_item_sel_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             relay_coil_o,
  output gfs_loop_t        loop_level_o,
  output logic             flash_full_o,
  output logic             fault_msg_o,
  output gfs_state_t       menu_state_o,
  output logic [3:0]       view_fault_o,
  output logic             choice_yes_o,
  output logic             replace_cell_o
);
  logic [25:0]     tick_cnt_reg;  // Second prescaler
  logic            tick_reg;      // One-second pulse
  logic [16:0]     day_sec_reg;   // Seconds within a day
  logic [8:0]      days_reg;      // Days since good span
  logic [5:0]      msg_sec_reg;   // Fault message interval
  logic [3:0]      hold_s_reg;    // Seconds magnet held
  logic [3:0]      idle_s_reg;    // Seconds without input
  logic            held_q_reg;    // Switch held last cycle
  logic            hold_used_reg; // Hold already acted on
  logic [25:0]     phase_reg;     // Sub-second phase of magnet timers
  logic [25:0]     dwell_cyc_reg; // Cycles spent on shown fault
  logic [15:0]     status_reg;    // Fault status word
  logic [1:0]      ctrl_reg;      // Latching, energized
  logic            shadow_reg;    // Value being edited
  logic            relay_act_reg; // Relay active state
  logic [6:0]      life_reg;      // Remaining cell life
  logic [15:0]     conc_reg;      // Serial concentration
  gfs_state_t      state_reg;     // Menu state
  gfs_loop_t       loop_reg;      // Loop output level
  logic            fmsg_reg;      // Message pulse
  logic [3:0]      vidx_reg;      // Fault shown in view
  logic [31:0]     rdata_reg;     // Read data
  logic            held, released, swipe, excused, sec_done;
  logic            any_fault, disabling;
  logic [15:0]     status_next;

  // Range test on a signed 17-bit value
  function automatic logic outside(input logic signed [16:0] v, input int lo, input int hi);
    outside = (v < 17'(lo)) || (v > 17'(hi));
  endfunction

  assign held     = magnet_switch_up_i | magnet_switch_down_i;
  assign released = held_q_reg & ~held;
  assign swipe    = released & (hold_s_reg < 4'(VIEW_HOLD_S));
  // Hold and idle seconds count from the last press or release, so a short swipe never straddles a tick
  assign sec_done = (held == held_q_reg) && (phase_reg == 26'(TICK - 1));

  // Fault word assembly
  always_comb begin
    status_next = status_reg;
    status_next[B_TEMP]  = outside(17'(meas_i.temp), TEMP_MIN, TEMP_MAX);
    status_next[B_CELL]  = outside({1'b0, meas_i.bridge_ma}, BRIDGE_MA_NOM - BRIDGE_MA_TOL,
                                   BRIDGE_MA_NOM + BRIDGE_MA_TOL)
                         | outside({1'b0, meas_i.bridge_cv}, BRIDGE_CV_MIN, BRIDGE_CV_MAX);
    status_next[B_PROC]  = cal_i.proc_err;
    status_next[B_MEM]   = cal_i.mem_err;
    status_next[B_LOOP]  = meas_i.loop_ohm > 16'(LOOP_OHM_MAX);
    status_next[B_VIN]   = outside({1'b0, meas_i.supply_cv}, SUPPLY_CV_MIN, SUPPLY_CV_MAX);
    status_next[B_SPAN]  = days_reg >= 9'(SPAN_DUE_DAYS);
    status_next[B_INCAL] = cal_i.zero_active | cal_i.span_active;
    // Sticky calibration faults; a new failure wins over a success
    if (cal_i.zero_ok) status_next[B_ZERO] = 1'b0;
    if (meas_i.gas < 16'(ZERO_DRIFT_MIN)) status_next[B_ZERO] = 1'b1;
    if (cal_i.span_ok) begin
      status_next[B_RANGE] = 1'b0;
      status_next[B_STAB]  = 1'b0;
      status_next[B_CLEAR] = 1'b0;
    end
    if (cal_i.span_range_fail) status_next[B_RANGE] = 1'b1;
    if (cal_i.span_stab_fail) begin
      status_next[B_STAB]  = 1'b1;
      status_next[B_CLEAR] = 1'b1;
    end
    status_next[B_GLOBAL] = |{status_next[B_ZERO:B_CLEAR], status_next[B_PROC:B_LOOP]};
  end

  assign disabling = status_next[B_GLOBAL];
  assign any_fault = |status_next[B_ZERO:B_SPAN];
  // Calibration result faults do not drop the loop while a calibration runs
  assign excused = status_next[B_INCAL] & ~|{status_next[B_CELL], status_next[B_PROC:B_LOOP]};

  // Status word register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= 16'h0000;
    end else begin
      status_reg <= status_next;
    end
  end

  // One-second tick
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 26'h0000000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 26'(TICK - 1)) begin
      tick_cnt_reg <= 26'h0000000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 26'h0000001;
      tick_reg     <= 1'b0;
    end
  end

  // Days since last good span calibration
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      day_sec_reg <= 17'h00000;
      days_reg    <= 9'h000;
    end else if (cal_i.span_ok) begin
      day_sec_reg <= 17'h00000;
      days_reg    <= 9'h000;
    end else if (tick_reg) begin
      if (day_sec_reg == 17'(DAY_SECS - 1)) begin
        day_sec_reg <= 17'h00000;
        if (days_reg != 9'h1FF) days_reg <= days_reg + 9'h001;
      end else begin
        day_sec_reg <= day_sec_reg + 17'h00001;
      end
    end
  end

  // Cell life capture after span calibration
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      life_reg       <= LIFE_RST;
      replace_cell_o <= 1'b0;
    end else begin
      if (cal_i.span_ok) begin
        life_reg <= (cal_i.life > 7'(LIFE_MAX)) ? 7'(LIFE_MAX) : cal_i.life;
      end
      replace_cell_o <= life_reg < 7'(LIFE_REPLACE);
    end
  end

  // Loop level, over-range flash and serial concentration
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_reg     <= LOOP_MEAS;
      flash_full_o <= 1'b0;
      conc_reg     <= 16'h0000;
    end else begin
      if (disabling && !excused) loop_reg <= LOOP_0MA;
      else if (status_next[B_INCAL]) loop_reg <= LOOP_2MA;
      else if (meas_i.gas > 16'(FULL_SCALE)) loop_reg <= LOOP_22MA;
      else loop_reg <= LOOP_MEAS;
      flash_full_o <= meas_i.gas > 16'(FULL_SCALE);
      conc_reg     <= (meas_i.gas > 16'(SERIAL_CAP)) ? 16'(SERIAL_CAP) : meas_i.gas;
    end
  end

  // Fault relay activity and coil drive
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      relay_act_reg <= 1'b0;
      relay_coil_o  <= 1'b0;
    end else begin
      if (disabling) relay_act_reg <= 1'b1;
      else if (!ctrl_reg[CTRL_LATCH]) relay_act_reg <= 1'b0;
      else if (swipe) relay_act_reg <= 1'b0;
      relay_coil_o <= ctrl_reg[CTRL_ENERG] ^ relay_act_reg;
    end
  end

  // Fault detected message interval
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      msg_sec_reg <= 6'h00;
      fmsg_reg    <= 1'b0;
    end else begin
      fmsg_reg <= 1'b0;
      if (!any_fault || state_reg != ST_NORMAL) begin
        msg_sec_reg <= 6'h00;
      end else if (tick_reg) begin
        if (msg_sec_reg == 6'(FAULT_MSG_S - 1)) begin
          msg_sec_reg <= 6'h00;
          fmsg_reg    <= 1'b1;
        end else begin
          msg_sec_reg <= msg_sec_reg + 6'h01;
        end
      end
    end
  end

  // Magnet hold and idle timers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_q_reg <= 1'b0;
      phase_reg  <= 26'h0000000;
      hold_s_reg <= 4'h0;
      idle_s_reg <= 4'h0;
    end else begin
      held_q_reg <= held;
      if (held != held_q_reg || sec_done) phase_reg <= 26'h0000000;
      else phase_reg <= phase_reg + 26'h0000001;
      if (!held) hold_s_reg <= 4'h0;
      else if (sec_done && hold_s_reg != 4'hF) hold_s_reg <= hold_s_reg + 4'h1;
      if (held || state_reg == ST_NORMAL) idle_s_reg <= 4'h0;
      else if (sec_done && idle_s_reg != 4'hF) idle_s_reg <= idle_s_reg + 4'h1;
    end
  end

  // Operator menu, fault view and settings
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_NORMAL;
      shadow_reg    <= 1'b0;
      hold_used_reg <= 1'b0;
      vidx_reg      <= 4'h0;
      dwell_cyc_reg <= 26'h0000000;
    end else begin
      if (!held) hold_used_reg <= 1'b0;
      case (state_reg)
        ST_NORMAL: begin
          if (fault_item_sel_i) state_reg <= ST_ITEM;
          else if (any_fault && hold_s_reg >= 4'(VIEW_HOLD_S)) begin
            state_reg <= ST_VIEW;
            vidx_reg  <= 4'(B_SPAN);
            dwell_cyc_reg <= 26'h0000000;
          end
        end
        ST_VIEW: begin
          // Full second on each active bit, inactive ones skipped at once
          if (status_reg[vidx_reg] && dwell_cyc_reg != 26'(TICK - 1)) begin
            dwell_cyc_reg <= dwell_cyc_reg + 26'h0000001;
          end else begin
            dwell_cyc_reg <= 26'h0000000;
            if (vidx_reg == 4'(B_ZERO)) state_reg <= ST_NORMAL;
            else vidx_reg <= vidx_reg + 4'h1;
          end
        end
        ST_ITEM: begin
          if (hold_s_reg >= 4'(PROMPT_S + ENTRY_HOLD_S) && !hold_used_reg) begin
            state_reg     <= ST_SET_LATCH;
            shadow_reg    <= ctrl_reg[CTRL_LATCH];
            hold_used_reg <= 1'b1;
          end
        end
        ST_SET_LATCH, ST_SET_ENERG: begin
          if (released && hold_s_reg < 4'(SAVE_HOLD_S) && !hold_used_reg) begin
            shadow_reg <= ~shadow_reg;
          end else if (magnet_switch_down_i && hold_s_reg >= 4'(SAVE_HOLD_S) && !hold_used_reg) begin
            hold_used_reg <= 1'b1;
            shadow_reg    <= ctrl_reg[CTRL_ENERG];
            state_reg     <= (state_reg == ST_SET_LATCH) ? ST_SET_ENERG : ST_ITEM;
          end
        end
        default: state_reg <= ST_NORMAL;
      endcase
      if (state_reg != ST_NORMAL && state_reg != ST_VIEW && idle_s_reg >= 4'(IDLE_TIMEOUT_S)) begin
        state_reg <= ST_NORMAL;
      end
    end
  end

  // Relay configuration, from menu save or bus write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_i && addr_i == A_CTRL) begin
      ctrl_reg <= wdata_i[1:0];
    end else if (magnet_switch_down_i && hold_s_reg >= 4'(SAVE_HOLD_S) && !hold_used_reg) begin
      if (state_reg == ST_SET_LATCH) ctrl_reg[CTRL_LATCH] <= shadow_reg;
      if (state_reg == ST_SET_ENERG) ctrl_reg[CTRL_ENERG] <= shadow_reg;
    end
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        A_CTRL:   rdata_reg <= {30'h00000000, ctrl_reg};
        A_STATUS: rdata_reg <= {16'h0000, status_reg};
        A_LIFE:   rdata_reg <= {25'h0000000, life_reg};
        A_DAYS:   rdata_reg <= {23'h000000, days_reg};
        A_CONC:   rdata_reg <= {16'h0000, conc_reg};
        A_LOOP:   rdata_reg <= {30'h00000000, loop_reg};
        default:  rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign rdata_o      = rdata_reg;
  assign loop_level_o = loop_reg;
  assign fault_msg_o  = fmsg_reg;
  assign menu_state_o = state_reg;
  assign view_fault_o = vidx_reg;
  assign choice_yes_o = shadow_reg;

  // Checks
  relay_polarity_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    relay_coil_o == ($past(ctrl_reg[CTRL_ENERG]) ^ $past(relay_act_reg))) else $error("relay polarity");
  nolatch_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!disabling && !ctrl_reg[CTRL_LATCH]) |=> !relay_act_reg) else $error("relay did not drop");
  latch_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (relay_act_reg && ctrl_reg[CTRL_LATCH] && !swipe && !wr_i) |=> relay_act_reg) else $error("latch lost");
  disable_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (disabling && !status_next[B_INCAL]) |=> loop_reg == LOOP_0MA ##0 relay_act_reg) else $error("no 0mA");
  cal_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (status_next[B_INCAL] && !disabling) |=> loop_reg == LOOP_2MA && status_reg[B_INCAL]) else $error("no 2mA");
  over_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (meas_i.gas > 16'(FULL_SCALE) && !status_next[B_INCAL] && !disabling) |=> loop_reg == LOOP_22MA
    && flash_full_o && conc_reg <= 16'(SERIAL_CAP)) else $error("over-range");
  span_due_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    days_reg >= 9'(SPAN_DUE_DAYS) && !cal_i.span_ok |=> status_reg[B_SPAN]) else $error("span due");
  zero_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_reg[B_ZERO] && !cal_i.zero_ok |=> status_reg[B_ZERO]) else $error("zero fault lost");
  idle_exit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_ITEM && idle_s_reg >= 4'(IDLE_TIMEOUT_S)) |=> state_reg == ST_NORMAL) else $error("timeout");
endmodule

// ---- bench/gfs_operator_model.sv ----
// Operator model that moves the magnet over the two switches
`timescale 1ns/100ps
module gfs_operator_model (
  input  wire logic mclk_i,   // System clock
  output logic      up_o,     // Magnet over the up switch
  output logic      down_o    // Magnet over the down switch
);
  // Both switches free at start
  initial begin
    up_o = 1'b0;
    down_o = 1'b0;
  end
  // Hold one switch for a number of cycles, then release and pause
  task automatic press(input logic dn, input int cyc);
    @(posedge mclk_i);
    if (dn) begin
      down_o <= 1'b1;               // Save hold on down
    end else begin
      up_o <= 1'b1;                 // Entry, view or swipe
    end
    repeat (cyc) @(posedge mclk_i);
    up_o <= 1'b0;
    down_o <= 1'b0;
    repeat (4) @(posedge mclk_i);   // Released before any next hold
  endtask
endmodule

// ---- bench/gfs_supervisor_tb_top.sv ----
// Self-checking bench for the gas fault supervisor
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module gfs_supervisor_tb_top import gfs_pkg::*;;
  localparam int TK = 10;                  // Cycles per second, shortened
  localparam int DS = 3;                   // Seconds per day, shortened
  localparam gfs_meas_t NOM = {16'h0000, 16'h0019, 16'h00C8, 16'h00FA, 16'h01F4, 16'h0960};
  logic        mclk_i = 1'b0;              // Clock
  logic        rst_n_i = 1'b0;             // Reset, active low
  gfs_meas_t   meas_i = NOM;               // Measurements
  gfs_cal_t    cal_i = '0;                 // Calibration events
  logic        sel = 1'b0, wr = 1'b0, rd = 1'b0, up, dn;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, g;
  logic        coil, flash, msg, yes, repl;
  gfs_loop_t   lvl;
  gfs_state_t  st;
  logic [3:0]  vf;
  gfs_meas_t   m;
  int          error_cnt = 0, checked = 0, seed = 32'h0344, i, n;
  int          fb[13] = '{10, 10, 10, 10, 3, 4, 4, 2, 2, 6, 5, 15, 15};
  gfs_supervisor #(.TICK(TK), .DAY_SECS(DS)) gfs_supervisor_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .meas_i(meas_i), .cal_i(cal_i),
    .magnet_switch_up_i(up), .magnet_switch_down_i(dn), .fault_item_sel_i(sel),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .relay_coil_o(coil), .loop_level_o(lvl), .flash_full_o(flash), .fault_msg_o(msg),
    .menu_state_o(st), .view_fault_o(vf), .choice_yes_o(yes), .replace_cell_o(repl)
  );
  gfs_operator_model gfs_operator_model_inst (.mclk_i(mclk_i), .up_o(up), .down_o(dn));
  // Clock at 40 MHz
  always #12.5 mclk_i = ~mclk_i;
  // Expected loop level from forcing conditions
  function automatic gfs_loop_t loop_exp(input bit dis, input bit cal, input bit ovr);
    return dis ? LOOP_0MA : (cal ? LOOP_2MA : (ovr ? LOOP_22MA : LOOP_MEAS));
  endfunction
  // Expected status word for one broken measurement
  function automatic logic [31:0] st_exp(input int b);
    if (b > 11) return 32'h0;
    return (32'h1 << b) | ((b != 2) ? 32'h1 : 32'h0);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  // Let inputs reach status, loop and coil
  task automatic settle;
    tick(3);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  // Read and compare in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr <= a; rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // One-cycle pulse on a calibration event bit
  task automatic pls(input int b);
    @(posedge mclk_i);
    cal_i[b] <= 1'b1;
    @(posedge mclk_i);
    cal_i[b] <= 1'b0;
    settle();
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #(25 * 40000);
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    tick(2);
    rst_n_i <= 1'b1;
    settle();
    rd_chk(A_CTRL, 32'h0); rd_chk(A_LIFE, 32'h64); rd_chk(A_STATUS, 32'h0); rd_chk(8'h20, 32'h0);
    `CHK("coil", 1'b0, coil)
    for (i = 0; i < 4; i++) begin
      g = $random(seed);
      wr_reg(A_CTRL, g); rd_chk(A_CTRL, g & 32'h3); wr_reg(A_STATUS, g); rd_chk(A_STATUS, 32'h0);
      meas_i.gas <= {10'h0, g[5:0]};
      settle();
      `CHK("coil", g[1], coil)
      rd_chk(A_CONC, {26'h0, g[5:0]});
    end
    wr_reg(A_CTRL, 32'h0);
    done("registers");
    for (i = 0; i < 13; i++) begin
      m = NOM;
      case (i)
        0: m.bridge_ma = 16'h0095; 1: m.bridge_ma = 16'h00FB;
        2: m.bridge_cv = 16'h015F; 3: m.bridge_cv = 16'h00B3;
        4: m.loop_ohm = 16'h03E9; 5: m.supply_cv = 16'h047D; 6: m.supply_cv = 16'h0AF1;
        7: m.temp = 16'hFFD7; 8: m.temp = 16'h004C;
        11: m = {16'h0064, 16'hFFD8, 16'h0096, 16'h00B4, 16'h03E8, 16'h047E};
        12: m = {16'hFFF6, 16'h004B, 16'h00FA, 16'h015E, 16'h0000, 16'h0AF0};
        default: m = NOM;
      endcase
      meas_i <= m;
      cal_i.proc_err <= (i == 9);
      cal_i.mem_err <= (i == 10);
      settle();
      rd_chk(A_STATUS, st_exp(fb[i]));
      `CHK("loop", loop_exp(fb[i] < 11 && fb[i] != 2, 0, 0), lvl)
      `CHK("coil", (fb[i] < 11 && fb[i] != 2), coil)
      meas_i <= NOM; cal_i <= '0;
      settle();
      `CHK("coil off", 1'b0, coil)
    end
    done("faults");
    meas_i.gas <= 16'h0065; settle();
    `CHK("loop", loop_exp(0, 0, 1), lvl) `CHK("flash", 1'b1, flash)
    rd_chk(A_CONC, 32'h65); meas_i.gas <= 16'h0078; settle(); rd_chk(A_CONC, 32'h6E);
    cal_i.zero_active <= 1'b1; settle();
    `CHK("loop", loop_exp(0, 1, 1), lvl) rd_chk(A_STATUS, 32'h4000);
    cal_i.proc_err <= 1'b1; settle();
    `CHK("loop", loop_exp(1, 1, 1), lvl)
    cal_i <= '0; meas_i.gas <= 16'h0064; settle();
    `CHK("loop", LOOP_MEAS, lvl) `CHK("flash", 1'b0, flash)
    done("levels");
    meas_i.gas <= 16'hFFF5; settle(); meas_i.gas <= 16'h0000; settle();
    rd_chk(A_STATUS, 32'h0801); `CHK("loop", LOOP_0MA, lvl)
    pls(12); rd_chk(A_STATUS, 32'h0);
    pls(10); rd_chk(A_STATUS, 32'h0201);
    cal_i.life <= 7'h14; pls(11); rd_chk(A_STATUS, 32'h0); rd_chk(A_LIFE, 32'h14);
    `CHK("replace", 1'b1, repl)
    pls(9); rd_chk(A_STATUS, 32'h0181);
    cal_i.life <= 7'h19; pls(11); rd_chk(A_STATUS, 32'h0); `CHK("replace", 1'b0, repl)
    done("calibration");
    wr_reg(A_CTRL, 32'h1); cal_i.proc_err <= 1'b1; settle(); cal_i.proc_err <= 1'b0; settle();
    `CHK("latched", 1'b1, coil)
    gfs_operator_model_inst.press(0, 3); settle();
    `CHK("unlatched", 1'b0, coil)
    wr_reg(A_CTRL, 32'h2); cal_i.mem_err <= 1'b1; settle();
    `CHK("energized", 1'b0, coil) cal_i.mem_err <= 1'b0; settle(); `CHK("energized", 1'b1, coil)
    wr_reg(A_CTRL, 32'h0);
    done("relay");
    cal_i.mem_err <= 1'b1;
    n = 0;
    while (msg !== 1'b1 && n < 1000) begin @(posedge mclk_i); #1; n++; end
    `CHK("first msg", 1'b1, (n >= 59 * TK && n <= 60 * TK + 1))
    @(posedge mclk_i); #1; n = 1;
    while (msg !== 1'b1 && n < 1000) begin @(posedge mclk_i); #1; n++; end
    `CHK("msg gap", 1'b1, (n >= 598 && n <= 602))
    meas_i.loop_ohm <= 16'h03E9; settle();
    gfs_operator_model_inst.press(0, TK + 2); #1;
    `CHK("view", ST_VIEW, st) `CHK("item", 4'h3, vf) tick(TK); #1 `CHK("item", 4'h5, vf)
    tick(2 * TK); #1 `CHK("view end", ST_NORMAL, st)
    meas_i <= NOM; cal_i <= '0;
    done("view");
    @(posedge mclk_i); sel <= 1'b1; @(posedge mclk_i); sel <= 1'b0; settle();
    gfs_operator_model_inst.press(0, 5 * TK + 5); #1 `CHK("menu", ST_SET_LATCH, st)
    gfs_operator_model_inst.press(0, 3); #1 `CHK("yes", 1'b1, yes)
    gfs_operator_model_inst.press(1, 3); #1 `CHK("yes", 1'b0, yes)
    gfs_operator_model_inst.press(1, 3); gfs_operator_model_inst.press(1, 3 * TK + 3);
    #1 `CHK("menu", ST_SET_ENERG, st)
    gfs_operator_model_inst.press(0, 3); gfs_operator_model_inst.press(1, 3 * TK + 3);
    #1 `CHK("menu", ST_ITEM, st) rd_chk(A_CTRL, 32'h3);
    tick(14 * TK); #1 `CHK("idle", ST_ITEM, st) tick(2 * TK); #1 `CHK("idle", ST_NORMAL, st)
    wr_reg(A_CTRL, 32'h0);
    done("menu");
    pls(11); tick(178 * DS * TK); rd_chk(A_STATUS, 32'h0);
    tick(3 * DS * TK); rd_chk(A_STATUS, 32'h0002); `CHK("loop", LOOP_MEAS, lvl)
    done("overdue");
    wr_reg(A_CTRL, 32'h3); rst_n_i <= 1'b0; tick(2); rst_n_i <= 1'b1;
    rd_chk(A_CTRL, 32'h0); rd_chk(A_STATUS, 32'h0);
    done("reset");
    complete_run();
  end
endmodule
